// [hw/gpio_pkg.sv]
// Constants for the two general-purpose ports: register indexes, widths, reset values.
// Assumes an 8-bit core data bus addressing registers by a small index.
package gpio_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned FIRST_W = 8;
  localparam int unsigned SECOND_W = 6;
  localparam int unsigned SYNC_STAGES = 2;
  // Register indexes on the core data bus
  localparam logic [2:0] IDX_FIRST_PORT = 3'h0;
  localparam logic [2:0] IDX_FIRST_DIR = 3'h1;
  localparam logic [2:0] IDX_FIRST_PULL = 3'h2;
  localparam logic [2:0] IDX_FIRST_WAKE = 3'h3;
  localparam logic [2:0] IDX_SECOND_PORT = 3'h4;
  localparam logic [2:0] IDX_SECOND_DIR = 3'h5;
  localparam logic [2:0] IDX_SECOND_PULL = 3'h6;
  localparam logic [2:0] IDX_REMAP = 3'h7;
  // Reset values
  localparam logic [7:0] RST_FIRST_PORT = 8'hff;
  localparam logic [7:0] RST_FIRST_DIR = 8'hff;
  localparam logic [7:0] RST_FIRST_PULL = 8'h00;
  localparam logic [7:0] RST_FIRST_WAKE = 8'h00;
  localparam logic [5:0] RST_SECOND_PORT = 6'h3f;
  localparam logic [5:0] RST_SECOND_DIR = 6'h3f;
  localparam logic [5:0] RST_SECOND_PULL = 6'h00;
  localparam logic [7:0] RST_REMAP = 8'h50;
  // Upper bits of the second-port registers
  localparam logic [1:0] SECOND_UPPER_ZERO = 2'h0;
endpackage : gpio_pkg

// [hw/gpio_ports.sv]
// Two bidirectional ports with pull-high selection and first-port wake-up.
// Assumes a single-cycle core data bus on clk_sys and pads resolving enables.
`timescale 1ns/1ns
// Summary of operation
// RULE_01: Port reads sample pin levels directly at the read edge, no input latch; here reads see levels after a two-flop synchroniser.
// RULE_02: Written output data stays in the latch until rewritten.
// RULE_03: Every pin of both ports can be input or output.
// RULE_04: Pull-high acts only while the pin is an input.
// RULE_05: First-port pull-high bits enable matching pull-highs when one.
// RULE_06: Second-port pull-high bits five to zero enable pull-highs.
// RULE_07: Upper two bits of second-port registers read as zero.
// RULE_08: Enabled first-port pin falling high to low wakes the core.
// RULE_09: Each first-port wake-up bit enables that pin's wake-up.
// RULE_10: Direction one makes an input; zero makes a CMOS output.
// RULE_11: Reading an output pin returns the latch, not the pin.
// RULE_12: Registers reset on all resets except watchdog reset in idle.
// RULE_13: Wake-up detection works without the system clock; here only the per-pin flags do, core_wake is raised through clk_sys flops.
module gpio_ports (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic idle_wdt_reset_n,
  // Core data bus
  input wire logic [gpio_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [gpio_pkg::DATA_W-1:0] bus_wdata,
  output logic [gpio_pkg::DATA_W-1:0] bus_rdata,
  // Power mode
  input wire logic core_asleep,
  output logic core_wake,
  // First port pins
  input wire logic [gpio_pkg::FIRST_W-1:0] first_port_in,
  output logic [gpio_pkg::FIRST_W-1:0] first_port_out,
  output logic [gpio_pkg::FIRST_W-1:0] first_port_oe_n,
  output logic [gpio_pkg::FIRST_W-1:0] first_port_pullhigh_on,
  // Second port pins
  input wire logic [gpio_pkg::SECOND_W-1:0] second_port_in,
  output logic [gpio_pkg::SECOND_W-1:0] second_port_out,
  output logic [gpio_pkg::SECOND_W-1:0] second_port_oe_n,
  output logic [gpio_pkg::SECOND_W-1:0] second_port_pullhigh_on,
  // Remap control to pin-function logic
  output logic [gpio_pkg::DATA_W-1:0] pin_remap_control
);
  import gpio_pkg::*;

  logic [7:0] first_port_reg, first_port_next;
  logic [7:0] first_dir_reg, first_dir_next;
  logic [7:0] first_pull_reg, first_pull_next;
  logic [7:0] first_wake_reg, first_wake_next;
  logic [5:0] second_port_reg, second_port_next;
  logic [5:0] second_dir_reg, second_dir_next;
  logic [5:0] second_pull_reg, second_pull_next;
  logic [7:0] remap_reg, remap_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] first_oe_n_reg, first_oe_n_next;
  logic [7:0] first_ph_reg, first_ph_next;
  logic [5:0] second_oe_n_reg, second_oe_n_next;
  logic [5:0] second_ph_reg, second_ph_next;
  logic wake_reg, wake_next;
  logic wake_ack_reg, wake_ack_next;
  logic [7:0] first_sync;
  logic [5:0] second_sync;
  logic [7:0] wake_flag;
  logic [1:0] wake_seen_meta_reg, wake_seen_reg;
  logic cfg_rst_n;

  // RULE_12: idle watchdog reset leaves registers
  assign cfg_rst_n = rst_n;

  // RULE_01: pins pass two flops only, no latch
  pin_sync #(.WIDTH(FIRST_W)) u_sync_first (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(first_port_in),
    .sync_out(first_sync)
  );

  pin_sync #(.WIDTH(SECOND_W)) u_sync_second (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(second_port_in),
    .sync_out(second_sync)
  );

  // RULE_08: falling edge wake per pin
  wake_detect #(.WIDTH(FIRST_W)) u_wake (
    .rst_n(rst_n),
    .wake_ack(wake_ack_reg),
    .pin_in(first_port_in),
    .wake_en(first_wake_reg),
    .wake_flag(wake_flag)
  );

  // Any-flag level brought into clk_sys
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_seen_meta_reg <= 2'h0;
      wake_seen_reg <= 2'h0;
    end else begin
      wake_seen_meta_reg <= {1'b0, |wake_flag};
      wake_seen_reg <= wake_seen_meta_reg;
    end
  end

  // Register writes
  always_comb begin
    first_port_next = first_port_reg;
    first_dir_next = first_dir_reg;
    first_pull_next = first_pull_reg;
    first_wake_next = first_wake_reg;
    second_port_next = second_port_reg;
    second_dir_next = second_dir_reg;
    second_pull_next = second_pull_reg;
    remap_next = remap_reg;
    // RULE_12: idle watchdog reset blocks writes
    if (bus_wr && idle_wdt_reset_n) begin
      case (bus_addr)
        // RULE_02: latch changes only on write
        IDX_FIRST_PORT: first_port_next = bus_wdata;
        IDX_FIRST_DIR: first_dir_next = bus_wdata;
        // RULE_05: first pull-high bits
        IDX_FIRST_PULL: first_pull_next = bus_wdata;
        // RULE_09: per-pin wake enable
        IDX_FIRST_WAKE: first_wake_next = bus_wdata;
        IDX_SECOND_PORT: second_port_next = bus_wdata[5:0];
        IDX_SECOND_DIR: second_dir_next = bus_wdata[5:0];
        // RULE_06: second pull-high bits
        IDX_SECOND_PULL: second_pull_next = bus_wdata[5:0];
        IDX_REMAP: remap_next = bus_wdata;
        default: begin
        end
      endcase
    end
  end

  // RULE_12: reset values on all listed resets
  always_ff @(posedge clk_sys or negedge cfg_rst_n) begin
    if (!cfg_rst_n) begin
      first_port_reg <= RST_FIRST_PORT;
      first_dir_reg <= RST_FIRST_DIR;
      first_pull_reg <= RST_FIRST_PULL;
      first_wake_reg <= RST_FIRST_WAKE;
      second_port_reg <= RST_SECOND_PORT;
      second_dir_reg <= RST_SECOND_DIR;
      second_pull_reg <= RST_SECOND_PULL;
      remap_reg <= RST_REMAP;
    end else begin
      first_port_reg <= first_port_next;
      first_dir_reg <= first_dir_next;
      first_pull_reg <= first_pull_next;
      first_wake_reg <= first_wake_next;
      second_port_reg <= second_port_next;
      second_dir_reg <= second_dir_next;
      second_pull_reg <= second_pull_next;
      remap_reg <= remap_next;
    end
  end

  // Read path and pad drive
  always_comb begin
    rdata_next = rdata_reg;
    if (bus_rd) begin
      case (bus_addr)
        // RULE_11: output pins read the latch
        // RULE_10: input pins read the level
        IDX_FIRST_PORT: rdata_next = (first_sync & first_dir_reg) |
                                     (first_port_reg & ~first_dir_reg);
        IDX_FIRST_DIR: rdata_next = first_dir_reg;
        IDX_FIRST_PULL: rdata_next = first_pull_reg;
        IDX_FIRST_WAKE: rdata_next = first_wake_reg;
        // RULE_07: upper bits read zero
        IDX_SECOND_PORT: rdata_next = {SECOND_UPPER_ZERO,
                                       (second_sync & second_dir_reg) |
                                       (second_port_reg & ~second_dir_reg)};
        IDX_SECOND_DIR: rdata_next = {SECOND_UPPER_ZERO, second_dir_reg};
        IDX_SECOND_PULL: rdata_next = {SECOND_UPPER_ZERO, second_pull_reg};
        IDX_REMAP: rdata_next = remap_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    // RULE_03: every pin bidirectional
    // RULE_10: direction zero drives
    first_oe_n_next = first_dir_reg;
    second_oe_n_next = second_dir_reg;
    // RULE_04: pull-high only as input
    first_ph_next = first_pull_reg & first_dir_reg;
    second_ph_next = second_pull_reg & second_dir_reg;
    // RULE_08: wake while asleep
    wake_next = core_asleep & wake_seen_reg[0];
    wake_ack_next = wake_seen_reg[0] & ~core_asleep;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      first_oe_n_reg <= 8'hff;
      first_ph_reg <= 8'h00;
      second_oe_n_reg <= 6'h3f;
      second_ph_reg <= 6'h00;
      wake_reg <= 1'b0;
      wake_ack_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      first_oe_n_reg <= first_oe_n_next;
      first_ph_reg <= first_ph_next;
      second_oe_n_reg <= second_oe_n_next;
      second_ph_reg <= second_ph_next;
      wake_reg <= wake_next;
      wake_ack_reg <= wake_ack_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign first_port_out = first_port_reg;
  assign second_port_out = second_port_reg;
  assign first_port_oe_n = first_oe_n_reg;
  assign second_port_oe_n = second_oe_n_reg;
  assign first_port_pullhigh_on = first_ph_reg;
  assign second_port_pullhigh_on = second_ph_reg;
  assign pin_remap_control = remap_reg;
  assign core_wake = wake_reg;

  // Checks
  sequence s_write_dir(logic [2:0] idx);
    bus_wr && bus_addr == idx && idle_wdt_reset_n;
  endsequence

  sequence s_read_at(logic [2:0] idx);
    bus_rd && bus_addr == idx;
  endsequence

  sequence s_write_then_quiet(logic [2:0] idx);
    s_write_dir(idx) ##1 !bus_wr;
  endsequence

  sequence s_wake_seen;
    wake_seen_reg[0] && core_asleep;
  endsequence

  chk_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    !(bus_wr && bus_addr == IDX_FIRST_PORT) |=> $stable(first_port_reg))
    else $error("first port latch changed without a write");
  chk_pull_gating: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    ##1 (first_port_pullhigh_on & ~first_port_oe_n) == 8'h00)
    else $error("pull-high on an output pin");
  chk_first_pull_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    s_write_dir(IDX_FIRST_PULL) |=> first_pull_reg == $past(bus_wdata))
    else $error("first pull-high write lost");
  chk_second_pull_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    s_write_dir(IDX_SECOND_PULL) |=> second_pull_reg == $past(bus_wdata[5:0]))
    else $error("second pull-high write lost");
  chk_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    bus_rd && bus_addr[2] && bus_addr != IDX_REMAP |=> bus_rdata[7:6] == 2'h0)
    else $error("second port upper bits not zero");
  chk_dir_drive: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
    s_write_dir(IDX_FIRST_DIR) |=> ##1 first_port_oe_n == $past(bus_wdata, 2))
    else $error("direction did not reach pad enable");
  chk_read_latch: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    bus_rd && bus_addr == IDX_FIRST_PORT |=>
      ((bus_rdata ^ $past(first_port_reg)) & ~$past(first_dir_reg)) == 8'h00)
    else $error("output pin read not from latch");
  chk_wake_asleep: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    core_wake |-> $past(core_asleep))
    else $error("wake raised while not asleep");
  chk_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
    !idle_wdt_reset_n |=> $stable(first_dir_reg) && $stable(remap_reg))
    else $error("register changed during idle watchdog reset");
  chk_idle_hold_ports: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
    !idle_wdt_reset_n |=> $stable(first_port_reg) && $stable(second_port_reg) &&
      $stable(first_pull_reg) && $stable(first_wake_reg))
    else $error("port register changed during idle watchdog reset");

  // Read sources per pin direction
  chk_first_input_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    s_read_at(IDX_FIRST_PORT) |=>
      ((bus_rdata ^ $past(first_sync)) & $past(first_dir_reg)) == 8'h00)
    else $error("first port input read not from pin level");
  chk_second_input_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    s_read_at(IDX_SECOND_PORT) |=>
      ((bus_rdata[5:0] ^ $past(second_sync)) & $past(second_dir_reg)) == 6'h00)
    else $error("second port input read not from pin level");
  chk_second_read_latch: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    s_read_at(IDX_SECOND_PORT) |=>
      ((bus_rdata[5:0] ^ $past(second_port_reg)) & ~$past(second_dir_reg)) == 6'h00)
    else $error("second port output read not from latch");

  // Writes reaching latches and pads
  chk_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    s_write_dir(IDX_FIRST_PORT) |=> first_port_reg == $past(bus_wdata))
    else $error("first port latch write lost");
  chk_second_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    s_write_dir(IDX_SECOND_PORT) |=> second_port_reg == $past(bus_wdata[5:0]))
    else $error("second port latch write lost");
  chk_second_dir_drive: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
    s_write_dir(IDX_SECOND_DIR) |=> ##1 second_port_oe_n == $past(bus_wdata[5:0], 2))
    else $error("second direction did not reach pad enable");
  chk_second_pull_gating: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    ##1 (second_port_pullhigh_on & ~second_port_oe_n) == 6'h00)
    else $error("second port pull-high on an output pin");
  chk_first_pull_drive: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    s_write_then_quiet(IDX_FIRST_PULL) ##0 $past(first_dir_reg) == 8'hff |=>
      first_port_pullhigh_on == $past(bus_wdata, 2))
    else $error("first pull-high bits did not reach input pins");
  chk_second_pull_drive: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    s_write_then_quiet(IDX_SECOND_PULL) ##0 $past(second_dir_reg) == 6'h3f |=>
      second_port_pullhigh_on == $past(bus_wdata[5:0], 2))
    else $error("second pull-high bits did not reach input pins");

  // Wake enable and wake output
  chk_wake_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    s_write_dir(IDX_FIRST_WAKE) |=> first_wake_reg == $past(bus_wdata))
    else $error("wake enable write lost");
  chk_wake_follows: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    s_wake_seen |=> core_wake)
    else $error("seen wake flag did not wake the core");
  chk_wake_cleared: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    !core_asleep |=> !core_wake)
    else $error("wake held while core awake");
endmodule : gpio_ports

// [hw/pin_sync.sv]
// Two-stage synchroniser for a vector of pin levels.
// Assumes inputs come from outside the clk_sys domain.
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : pin_sync

// [hw/wake_detect.sv]
// Falling-edge wake detector for the first port, clocked by the pins themselves.
// Assumes pins are glitch free; wake_ack comes from the running core clock side.
`timescale 1ns/1ns
module wake_detect #(
  parameter int unsigned WIDTH = 8
) (
  // Reset and clear
  input wire logic rst_n,
  input wire logic wake_ack,
  // Pins and enables
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] wake_en,
  // Per-pin wake flags
  output logic [WIDTH-1:0] wake_flag
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic flag_reg;
      // RULE_13: no system clock used
      always_ff @(negedge pin_in[g] or negedge rst_n or posedge wake_ack) begin
        if (!rst_n) begin
          flag_reg <= 1'b0;
        end else if (wake_ack) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= wake_en[g];
        end
      end
      assign wake_flag[g] = flag_reg;
    end
  endgenerate
endmodule : wake_detect

// [sim/pin_board.sv]
// External pin board: resolves each pad from design drive, switch drive and pull-high.
// Assumes oe_n low means the design drives the pad; an undriven pad wanders each cycle.
`timescale 1ns/1ns
module pin_board #(
  parameter int unsigned WIDTH = 8
) (
  // Clock
  input wire logic clk_sys,
  // Design side
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe_n,
  input wire logic [WIDTH-1:0] pad_pullhigh_on,
  // Switch side
  input wire logic [WIDTH-1:0] ext_en,
  input wire logic [WIDTH-1:0] ext_val,
  // Resolved level
  output logic [WIDTH-1:0] pad_level
);
  logic [WIDTH-1:0] wander_reg = '0;
  always @(posedge clk_sys) begin
    wander_reg <= ~wander_reg;
  end
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (!pad_oe_n[i]) pad_level[i] = pad_out[i];
      else if (ext_en[i]) pad_level[i] = ext_val[i];
      else if (pad_pullhigh_on[i]) pad_level[i] = 1'b1;
      else pad_level[i] = wander_reg[i];
    end
  end
endmodule : pin_board

// [sim/tb_gpio_ports.sv]
// Self-checking bench for the two ports, with a register model and pin board.
// Assumes the single-cycle core bus and registered read data of the design.
`timescale 1ns/1ns
module tb_gpio_ports;
  import gpio_pkg::*;
  logic clk_sys, rst_n, idle_wdt_reset_n, bus_wr, bus_rd, core_asleep, core_wake;
  logic [2:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, pin_remap_control, rd_val;
  logic [7:0] fo, foe_n, fpu, fin, ext_en_a, ext_val_a;
  logic [5:0] so, soe_n, spu, sin, ext_en_b, ext_val_b;
  logic [7:0] mdl [8];
  int errors = 0;
  int total_checks = 0;
  gpio_ports dut (.clk_sys(clk_sys), .rst_n(rst_n), .idle_wdt_reset_n(idle_wdt_reset_n),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .core_asleep(core_asleep), .core_wake(core_wake),
    .first_port_in(fin), .first_port_out(fo), .first_port_oe_n(foe_n),
    .first_port_pullhigh_on(fpu), .second_port_in(sin), .second_port_out(so),
    .second_port_oe_n(soe_n), .second_port_pullhigh_on(spu),
    .pin_remap_control(pin_remap_control));
  pin_board #(.WIDTH(8)) board_a (.clk_sys(clk_sys), .pad_out(fo), .pad_oe_n(foe_n),
    .pad_pullhigh_on(fpu), .ext_en(ext_en_a), .ext_val(ext_val_a), .pad_level(fin));
  pin_board #(.WIDTH(6)) board_b (.clk_sys(clk_sys), .pad_out(so), .pad_oe_n(soe_n),
    .pad_pullhigh_on(spu), .ext_en(ext_en_b), .ext_val(ext_val_b), .pad_level(sin));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask : rd_reg
  task automatic mdl_write(input logic [2:0] a, input logic [7:0] d);
    mdl[a] = (a >= 3'h4 && a <= 3'h6) ? (d & 8'h3f) : d;
  endtask : mdl_write
  function automatic logic [7:0] exp_read(input logic [2:0] a);
    logic [7:0] pin_a, pin_b;
    pin_a = ext_en_a ? (ext_en_a & ext_val_a) | ~ext_en_a : 8'hff;
    pin_b = {2'h0, (ext_en_b & ext_val_b) | ~ext_en_b};
    if (a == IDX_FIRST_PORT) return (mdl[1] & pin_a) | (~mdl[1] & mdl[0]);
    if (a == IDX_SECOND_PORT) return ((mdl[5] & pin_b) | (~mdl[5] & mdl[4])) & 8'h3f;
    return mdl[a];
  endfunction : exp_read
  task automatic set_pins();
    ext_val_a = 8'($urandom);
    ext_en_a = 8'($urandom) | ~mdl[2];
    ext_val_b = 6'($urandom);
    ext_en_b = 6'($urandom) | ~mdl[6][5:0];
  endtask : set_pins
  task automatic check_all();
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      rd_reg(3'(i), rd_val);
      check(rd_val, exp_read(3'(i)));
    end
    check(fo, mdl[0]);
    check(foe_n, mdl[1]);
    check(fpu, mdl[1] & mdl[2]);
    check({2'h0, so}, mdl[4]);
    check({2'h0, soe_n}, mdl[5]);
    check({2'h0, spu}, mdl[5] & mdl[6]);
    check(pin_remap_control, mdl[7]);
  endtask : check_all
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    mdl = '{RST_FIRST_PORT, RST_FIRST_DIR, RST_FIRST_PULL, RST_FIRST_WAKE,
      {2'h0, RST_SECOND_PORT}, {2'h0, RST_SECOND_DIR}, {2'h0, RST_SECOND_PULL}, RST_REMAP};
    set_pins();
  endtask : do_reset
  initial begin
    #(40 * 20000);
    errors++;
    tally_and_finish();
  end
  initial begin
    {rst_n, idle_wdt_reset_n, bus_wr, bus_rd, core_asleep} = 5'b01000;
    {bus_addr, bus_wdata, ext_en_a, ext_val_a, ext_en_b, ext_val_b} = '0;
    void'($urandom(32'h7c1b3228));
    do_reset();
    check_all();
    for (int n = 0; n < 40; n++) begin
      wr_reg(3'($urandom % 8), 8'($urandom));
      mdl_write(bus_addr, bus_wdata);
      wr_reg(3'($urandom % 8), 8'($urandom));
      mdl_write(bus_addr, bus_wdata);
      set_pins();
      check_all();
    end
    idle_wdt_reset_n = 1'b0;
    wr_reg(IDX_FIRST_DIR, ~mdl[1]);
    wr_reg(IDX_REMAP, ~mdl[7]);
    idle_wdt_reset_n = 1'b1;
    check_all();
    wr_reg(IDX_FIRST_DIR, 8'hff);
    mdl_write(IDX_FIRST_DIR, 8'hff);
    wr_reg(IDX_FIRST_WAKE, 8'h08);
    mdl_write(IDX_FIRST_WAKE, 8'h08);
    {ext_en_a, ext_val_a} = 16'hffff;
    repeat (4) @(posedge clk_sys);
    #1;
    core_asleep = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check({7'h0, core_wake}, 8'h00);
    ext_val_a = 8'hf7;
    for (int i = 0; i < 10 && core_wake !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    check({7'h0, core_wake}, 8'h01);
    core_asleep = 1'b0;
    ext_val_a = 8'hff;
    repeat (6) @(posedge clk_sys);
    #1;
    check({7'h0, core_wake}, 8'h00);
    core_asleep = 1'b1;
    ext_val_a = 8'hdf;
    repeat (10) @(posedge clk_sys);
    #1;
    check({7'h0, core_wake}, 8'h00);
    core_asleep = 1'b0;
    check_all();
    do_reset();
    check_all();
    tally_and_finish();
  end
endmodule : tb_gpio_ports
